// [logic/vpd_check.sv]
// Module: decides whether a disable or enable instruction may proceed
`timescale 1ns/100ps
module vpd_check
  import vpd_pkg::*;
(
  input wire logic i_cop0_usable,
  input wire logic [3:0] i_release,
  input wire logic i_mt_present,
  input wire logic i_dis_bit,
  input wire logic i_is_disable,
  output logic [1:0] o_result,
  output logic o_effective
);
  wire is_old_release = i_release < VPD_MIN_RELEASE;
  wire nop_case = !i_mt_present || (i_is_disable && i_dis_bit);
  assign o_result = is_old_release ? VPD_RES_RI :
                    !i_cop0_usable ? VPD_RES_CPU : VPD_RES_OK;
  assign o_effective = !is_old_release && i_cop0_usable && !nop_case;
endmodule

// [logic/vpd_ctrl.sv]
// Module: virtual processor disable and enable control for one core
//
// Behaviour
// - Nonzero target field receives control value from before the change.
// - Disable bit set only after all other processors are disabled.
// - Fetch stops; disable retires after outstanding work drains.
// - Pending prefetches of targets are terminated.
// - Disable acts as type-0 barrier against other processors.
// - Waiting-for-interrupt processor ignores interrupts until re-enabled.
// - Load-linked paused processor stays stopped until re-enabled.
// - Enable resumes all other processors immediately as before.
// - Disable with bit already set is a no-operation.
// - Disabled processors see interrupts masked, enable bits untouched.
// - Issuing processor keeps taking interrupts normally.
// - External fetch enable and this disable must both permit fetch.
// - Disable acts only when oldest unretired, never speculatively.
// - Without multithreading support the disable is a no-operation.
// - Unusable control coprocessor raises coprocessor-unusable exception.
// - Releases before 6 raise reserved-instruction exception.
// - Targets are halted in any privilege mode.
`timescale 1ns/100ps
module vpd_ctrl
  import vpd_pkg::*;
#(
  parameter int NUM_VP = VPD_NUM_VP,
  parameter int IDX_W = 2
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_dvp_req,
  input wire logic i_evp_req,
  input wire logic [IDX_W-1:0] i_issuer,
  input wire logic [4:0] i_target_register_field,
  input wire logic i_oldest,
  input wire logic i_cop0_usable,
  input wire logic [3:0] i_release,
  input wire logic i_multithread_present_bit,
  input wire logic [NUM_VP-1:0] i_outstanding,
  input wire logic [NUM_VP-1:0] i_prefetch_busy,
  input wire logic [NUM_VP-1:0] i_store_pending,
  input wire logic [NUM_VP-1:0] i_ext_fetch_en,
  input wire logic [NUM_VP-1:0] i_irq,
  input wire logic [NUM_VP-1:0] i_waiting_irq,
  input wire logic [NUM_VP-1:0] i_waiting_ll,
  input wire logic [NUM_VP-1:0] i_load_linked_flag,
  output logic o_done,
  output logic [1:0] o_result,
  output logic o_wr_en,
  output logic [4:0] o_wr_idx,
  output logic [31:0] o_wr_data,
  output logic o_vp_disabled_bit,
  output logic [NUM_VP-1:0] o_kill_prefetch,
  output logic [NUM_VP-1:0] o_fetch_en,
  output logic [NUM_VP-1:0] o_irq,
  output logic [NUM_VP-1:0] o_wake_irq,
  output logic [NUM_VP-1:0] o_wake_ll
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  vpd_state_t state_r, state_nxt;
  logic [31:0] vp_control_reg_r, vp_control_reg_nxt;
  logic [31:0] old_ctrl_r, old_ctrl_nxt;
  logic [4:0] idx_r, idx_nxt;
  logic [NUM_VP-1:0] target_r, target_nxt;
  logic [NUM_VP-1:0] kill_r, kill_nxt;
  logic done_r, done_nxt;
  logic [1:0] result_r, result_nxt;
  logic wr_en_r, wr_en_nxt;
  logic [4:0] wr_idx_r, wr_idx_nxt;
  logic [31:0] wr_data_r, wr_data_nxt;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic [1:0] chk_res;
  logic chk_eff;
  wire dis_bit = vp_control_reg_r[VPD_DIS_POS];
  wire [NUM_VP-1:0] others = ~(NUM_VP'(1) << i_issuer);
  wire dvp_go = i_dvp_req && i_oldest && (state_r == VPD_IDLE);
  wire evp_go = i_evp_req && (state_r == VPD_IDLE);
  wire drained = ((i_outstanding | i_prefetch_busy) & target_r) == '0;
  wire synced = (i_store_pending & target_r) == '0;
  wire [31:0] ctrl_set = vp_control_reg_r | (32'h1 << VPD_DIS_POS);
  wire [31:0] ctrl_clr = vp_control_reg_r & ~(32'h1 << VPD_DIS_POS);

  // ------------------------------------------------------------
  // Legality check
  // ------------------------------------------------------------
  vpd_check u_check (
    .i_cop0_usable(i_cop0_usable),
    .i_release(i_release),
    .i_mt_present(i_multithread_present_bit),
    .i_dis_bit(dis_bit),
    .i_is_disable(i_dvp_req),
    .o_result(chk_res),
    .o_effective(chk_eff)
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    vp_control_reg_nxt = vp_control_reg_r;
    old_ctrl_nxt = old_ctrl_r;
    idx_nxt = idx_r;
    target_nxt = target_r;
    kill_nxt = '0;
    done_nxt = 1'b0;
    result_nxt = result_r;
    wr_en_nxt = 1'b0;
    wr_idx_nxt = wr_idx_r;
    wr_data_nxt = wr_data_r;
    case (state_r)
      VPD_IDLE: begin
        if (dvp_go) begin
          old_ctrl_nxt = vp_control_reg_r;
          idx_nxt = i_target_register_field;
          if (chk_eff) begin
            // Halt regardless of privilege mode
            target_nxt = others;
            state_nxt = VPD_STOP;
          end else begin
            // Exception or no-operation completes at once
            done_nxt = 1'b1;
            result_nxt = chk_res;
            wr_en_nxt = (chk_res == VPD_RES_OK) &&
                        (i_target_register_field != VPD_ZERO_REG);
            wr_idx_nxt = i_target_register_field;
            wr_data_nxt = vp_control_reg_r;
          end
        end else if (evp_go) begin
          done_nxt = 1'b1;
          result_nxt = chk_res;
          wr_en_nxt = (chk_res == VPD_RES_OK) &&
                      (i_target_register_field != VPD_ZERO_REG);
          wr_idx_nxt = i_target_register_field;
          wr_data_nxt = vp_control_reg_r;
          if (chk_eff) begin
            // Release all targets in one step
            target_nxt = '0;
            vp_control_reg_nxt = ctrl_clr;
          end
        end
      end
      VPD_STOP: begin
        // Terminate speculative activity of targets
        kill_nxt = target_r;
        state_nxt = VPD_DRAIN;
      end
      VPD_DRAIN: begin
        kill_nxt = target_r;
        if (drained) begin
          state_nxt = VPD_SYNC;
        end
      end
      VPD_SYNC: begin
        if (synced) begin
          state_nxt = VPD_DONE;
        end
      end
      VPD_DONE: begin
        // Bit set only once all others are stopped
        vp_control_reg_nxt = ctrl_set;
        done_nxt = 1'b1;
        result_nxt = VPD_RES_OK;
        wr_en_nxt = idx_r != VPD_ZERO_REG;
        wr_idx_nxt = idx_r;
        wr_data_nxt = old_ctrl_r;
        state_nxt = VPD_IDLE;
      end
      default: begin
        state_nxt = VPD_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= VPD_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      vp_control_reg_r <= VPD_CTRL_RST;
    end else begin
      vp_control_reg_r <= vp_control_reg_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      old_ctrl_r <= VPD_CTRL_RST;
    end else begin
      old_ctrl_r <= old_ctrl_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      idx_r <= VPD_ZERO_REG;
    end else begin
      idx_r <= idx_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      target_r <= '0;
    end else begin
      target_r <= target_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      kill_r <= '0;
    end else begin
      kill_r <= kill_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      done_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      result_r <= VPD_RES_NONE;
    end else begin
      result_r <= result_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_en_r <= 1'b0;
    end else begin
      wr_en_r <= wr_en_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_idx_r <= VPD_ZERO_REG;
    end else begin
      wr_idx_r <= wr_idx_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_data_r <= VPD_CTRL_RST;
    end else begin
      wr_data_r <= wr_data_nxt;
    end
  end

  // ------------------------------------------------------------
  // Per-processor gating
  // ------------------------------------------------------------
  // Issuer never in target set, so its interrupts pass
  for (genvar g = 0; g < NUM_VP; g++) begin : g_vp
    vpd_vp_gate u_gate (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_target(target_r[g]),
      .i_ext_fetch_en(i_ext_fetch_en[g]),
      .i_irq_in(i_irq[g]),
      .i_waiting_irq(i_waiting_irq[g]),
      .i_waiting_ll(i_waiting_ll[g]),
      .i_ll_flag(i_load_linked_flag[g]),
      .o_fetch_en(o_fetch_en[g]),
      .o_irq_out(o_irq[g]),
      .o_wake_irq(o_wake_irq[g]),
      .o_wake_ll(o_wake_ll[g])
    );
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_done = done_r;
  assign o_result = result_r;
  assign o_wr_en = wr_en_r;
  assign o_wr_idx = wr_idx_r;
  assign o_wr_data = wr_data_r;
  assign o_vp_disabled_bit = vp_control_reg_r[VPD_DIS_POS];
  assign o_kill_prefetch = kill_r;
endmodule

// [logic/vpd_pkg.sv]
// Package: constants and types for the virtual processor disable control
package vpd_pkg;
  localparam int VPD_NUM_VP = 4;
  localparam int VPD_DATA_W = 32;
  localparam int VPD_REG_IDX_W = 5;
  localparam int VPD_DIS_POS = 0;
  localparam logic [31:0] VPD_CTRL_RST = 32'h0000_0000;
  localparam logic [4:0] VPD_ZERO_REG = 5'h00;
  localparam logic [3:0] VPD_MIN_RELEASE = 4'h6;
  localparam logic [7:0] VPD_DRAIN_TIMEOUT = 8'hFF;
  typedef enum logic [2:0] {
    VPD_IDLE = 3'b000,
    VPD_STOP = 3'b001,
    VPD_DRAIN = 3'b010,
    VPD_SYNC = 3'b011,
    VPD_DONE = 3'b100
  } vpd_state_t;
  typedef enum logic [1:0] {
    VPD_RES_NONE = 2'b00,
    VPD_RES_OK = 2'b01,
    VPD_RES_CPU = 2'b10,
    VPD_RES_RI = 2'b11
  } vpd_result_t;
endpackage

// [logic/vpd_vp_gate.sv]
// Module: per-processor gating of fetch, interrupts and wake events
`timescale 1ns/100ps
module vpd_vp_gate (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_target,
  input wire logic i_ext_fetch_en,
  input wire logic i_irq_in,
  input wire logic i_waiting_irq,
  input wire logic i_waiting_ll,
  input wire logic i_ll_flag,
  output logic o_fetch_en,
  output logic o_irq_out,
  output logic o_wake_irq,
  output logic o_wake_ll
);
  logic fetch_r, irq_r, wake_irq_r, wake_ll_r;
  // Disable and external enable must both allow fetch
  wire fetch_nxt = i_ext_fetch_en && !i_target;
  // Interrupts masked while disabled, enable bit untouched
  wire irq_nxt = i_irq_in && !i_target;
  // Waits only end when not disabled
  wire wake_irq_nxt = i_waiting_irq && i_irq_in && !i_target;
  wire wake_ll_nxt = i_waiting_ll && !i_ll_flag && !i_target;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fetch_r <= 1'b0;
      irq_r <= 1'b0;
      wake_irq_r <= 1'b0;
      wake_ll_r <= 1'b0;
    end else begin
      fetch_r <= fetch_nxt;
      irq_r <= irq_nxt;
      wake_irq_r <= wake_irq_nxt;
      wake_ll_r <= wake_ll_nxt;
    end
  end
  assign o_fetch_en = fetch_r;
  assign o_irq_out = irq_r;
  assign o_wake_irq = wake_irq_r;
  assign o_wake_ll = wake_ll_r;
endmodule

// [test/tb.sv]
// Testbench: disable and enable sequences against a drain model
`timescale 1ns/100ps
module tb;
  import vpd_pkg::*;
  logic i_clk = 0, i_resetn = 0, i_dvp_req = 0, i_evp_req = 0, slow = 0;
  logic i_oldest = 0, i_cop0_usable = 1, i_multithread_present_bit = 1;
  logic [1:0] i_issuer = 2'h0;
  logic [4:0] i_target_register_field = 5'h00;
  logic [3:0] i_release = 4'h6, i_ext_fetch_en = 4'hF, i_irq = 4'h0;
  logic [3:0] i_waiting_irq = 4'h0, i_waiting_ll = 4'h0;
  logic [3:0] i_load_linked_flag = 4'hF, i_outstanding, i_prefetch_busy;
  logic [3:0] i_store_pending, o_kill_prefetch, o_fetch_en, o_irq;
  logic [3:0] o_wake_irq, o_wake_ll;
  logic o_done, o_wr_en, o_vp_disabled_bit;
  logic [1:0] o_result;
  logic [4:0] o_wr_idx;
  logic [31:0] o_wr_data, seed = 32'h12B926BD;
  logic [40:0] exp_q[$], msk_q[$], cur_exp, cur_msk;
  int err_total = 0, samples_checked = 0, cyc = 0;
  always #5 i_clk = ~i_clk;
  vpd_ctrl dut (.i_clk, .i_resetn, .i_dvp_req, .i_evp_req, .i_issuer,
    .i_target_register_field, .i_oldest, .i_cop0_usable, .i_release,
    .i_multithread_present_bit, .i_outstanding, .i_prefetch_busy,
    .i_store_pending, .i_ext_fetch_en, .i_irq, .i_waiting_irq,
    .i_waiting_ll, .i_load_linked_flag, .o_done, .o_result, .o_wr_en,
    .o_wr_idx, .o_wr_data, .o_vp_disabled_bit, .o_kill_prefetch,
    .o_fetch_en, .o_irq, .o_wake_irq, .o_wake_ll);
  vpd_vp_model u_vp (.i_clk, .i_resetn, .i_slow(slow),
    .i_fetch_en(o_fetch_en), .i_kill(o_kill_prefetch),
    .o_outstanding(i_outstanding), .o_prefetch_busy(i_prefetch_busy),
    .o_store_pending(i_store_pending));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(string name, logic [40:0] seen, logic [40:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    err_total += exp_q.size();
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic op(logic dis, logic [1:0] res, logic b, logic [31:0] old,
                    logic [3:0] fm);
    logic [31:0] r;
    logic wr;
    r = rnd();
    wr = (res == VPD_RES_OK) && (r[4:0] != 5'h00);
    i_target_register_field = r[4:0];
    slow = r[5];
    i_irq[0] = r[6];
    i_oldest = 1'b0;
    i_dvp_req = dis;
    i_evp_req = !dis;
    exp_q.push_back({res, wr, b, r[4:0], old});
    msk_q.push_back({fm, (fm[1] && wr) ? 37'h1F_FFFF_FFFF : 37'h0});
    for (int n = 0; n < 60; n++) begin
      @(posedge i_clk);
      #1;
      i_oldest = (n >= 2);
      if (dis && n < 3) check("early", 41'(o_done), 41'h0);
      if (o_done === 1'b1) break;
    end
    i_dvp_req = 1'b0;
    i_evp_req = 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  // ----
  // Result watcher and timeout
  // ----
  always @(negedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end else if (o_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("spare done", 41'h1, 41'h0);
      end else begin
        cur_exp = exp_q.pop_front();
        cur_msk = msk_q.pop_front();
        check("result", {o_result, o_wr_en, o_vp_disabled_bit, o_wr_idx,
          o_wr_data} & cur_msk, cur_exp & cur_msk);
      end
    end
  end
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (8) @(posedge i_clk);
    #1 i_resetn = 1'b1;
    i_waiting_irq = 4'h2;
    i_waiting_ll = 4'h4;
    op(1'b1, VPD_RES_OK, 1'b1, 32'h0, 4'hF);
    i_irq[1] = 1'b1;
    i_load_linked_flag[2] = 1'b0;
    repeat (2) @(posedge i_clk);
    #1 check("held", 41'({o_wake_irq[1], o_wake_ll[2], o_fetch_en[3:1]}),
      41'h0);
    op(1'b1, VPD_RES_OK, 1'b1, 32'h1, 4'hF);
    i_ext_fetch_en = 4'h7;
    op(1'b0, VPD_RES_OK, 1'b0, 32'h1, 4'hF);
    repeat (2) @(posedge i_clk);
    #1 check("resumed", 41'({o_fetch_en, o_irq[1], o_wake_ll[2],
      o_wake_irq[1]}), 41'h3F);
    i_ext_fetch_en = 4'hF;
    i_waiting_irq = 4'h0;
    i_waiting_ll = 4'h0;
    for (int k = 0; k < 3; k++) begin
      i_cop0_usable = (k != 0);
      i_release = (k == 1) ? 4'h5 : 4'h6;
      i_multithread_present_bit = (k != 2);
      op(1'b1, (k == 0) ? VPD_RES_CPU : (k == 1) ? VPD_RES_RI : VPD_RES_OK,
        1'b0, 32'h0, 4'hF);
    end
    i_cop0_usable = 1'b1;
    i_release = 4'h6;
    i_multithread_present_bit = 1'b1;
    for (int k = 0; k < 3; k++) begin
      op(1'b1, VPD_RES_OK, 1'b1, 32'h0, 4'hF);
      op(1'b0, VPD_RES_OK, 1'b0, 32'h1, 4'hF);
    end
    repeat (3) @(posedge i_clk);
    stop_test();
  end
endmodule

// [test/vpd_ctrl_sva.sv]
// Checker: port assertions for the disable control
`timescale 1ns/100ps
module vpd_ctrl_sva
  import vpd_pkg::*;
#(
  parameter int NUM_VP = VPD_NUM_VP,
  parameter int IDX_W = 2
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_dvp_req,
  input wire logic i_evp_req,
  input wire logic [IDX_W-1:0] i_issuer,
  input wire logic i_oldest,
  input wire logic i_cop0_usable,
  input wire logic [3:0] i_release,
  input wire logic i_multithread_present_bit,
  input wire logic [NUM_VP-1:0] i_ext_fetch_en,
  input wire logic [NUM_VP-1:0] i_irq,
  input wire logic o_done,
  input wire logic [1:0] o_result,
  input wire logic o_wr_en,
  input wire logic o_vp_disabled_bit,
  input wire logic [NUM_VP-1:0] o_kill_prefetch,
  input wire logic [NUM_VP-1:0] o_fetch_en,
  input wire logic [NUM_VP-1:0] o_irq
);
  logic [NUM_VP-1:0] oth;
  assign oth = ~(NUM_VP'(1) << i_issuer);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ----
  // Assertions
  // ----
  a_wr_with_done: assert property (o_wr_en |-> o_done)
    else $error("write without done");
  a_bit_set_last: assert property ($rose(o_vp_disabled_bit) |->
    o_done && $past(i_dvp_req) && $past(i_oldest) &&
    $past((o_fetch_en & oth) == '0)) else $error("bit set early");
  a_kill_when_clear: assert property ($rose(|o_kill_prefetch) |->
    !o_vp_disabled_bit && (o_kill_prefetch & ~oth) == '0)
    else $error("bad prefetch kill");
  a_others_gated: assert property (o_vp_disabled_bit |->
    (o_fetch_en & oth) == '0 && (o_irq & oth) == '0)
    else $error("others not gated");
  a_issuer_irq: assert property (o_irq[i_issuer] ==
    $past(i_irq[i_issuer])) else $error("issuer irq lost");
  a_ext_gate: assert property ((o_fetch_en & ~$past(i_ext_fetch_en)) == '0)
    else $error("fetch without ext enable");
  a_enable_clear: assert property (o_done && $past(i_evp_req) &&
    $past(i_multithread_present_bit) && o_result == VPD_RES_OK |->
    !o_vp_disabled_bit) else $error("bit kept");
  a_cpu_excpt: assert property (o_done && !$past(i_cop0_usable) &&
    $past(i_release) >= VPD_MIN_RELEASE |-> o_result == VPD_RES_CPU)
    else $error("no coprocessor exception");
  a_rel_excpt: assert property (o_done && $past(i_cop0_usable) &&
    $past(i_release) < VPD_MIN_RELEASE |-> o_result == VPD_RES_RI)
    else $error("no reserved exception");
  a_no_mt_noop: assert property (o_done &&
    !$past(i_multithread_present_bit) |-> !$rose(o_vp_disabled_bit))
    else $error("disable without mt");
  a_fetch_back: assert property ($fell(o_vp_disabled_bit) |=>
    (o_fetch_en & oth) == ($past(i_ext_fetch_en) & oth))
    else $error("fetch not restored");
  c_dis: cover property ($rose(o_vp_disabled_bit));
  c_en: cover property ($fell(o_vp_disabled_bit));
  c_ri: cover property (o_done && o_result == VPD_RES_RI);
endmodule
bind vpd_ctrl vpd_ctrl_sva #(.NUM_VP(NUM_VP), .IDX_W(IDX_W)) u_sva (
  .i_clk, .i_resetn, .i_dvp_req, .i_evp_req, .i_issuer, .i_oldest,
  .i_cop0_usable, .i_release, .i_multithread_present_bit, .i_ext_fetch_en,
  .i_irq, .o_done, .o_result, .o_wr_en, .o_vp_disabled_bit,
  .o_kill_prefetch, .o_fetch_en, .o_irq);

// [test/vpd_vp_model.sv]
// Partner: work in flight on the other processors
`timescale 1ns/100ps
module vpd_vp_model (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_slow,
  input wire logic [3:0] i_fetch_en,
  input wire logic [3:0] i_kill,
  output logic [3:0] o_outstanding,
  output logic [3:0] o_prefetch_busy,
  output logic [3:0] o_store_pending
);
  logic [3:0] work_r;
  logic [3:0] work_nxt;
  assign work_nxt = (|i_fetch_en[3:1]) ? (i_slow ? 4'h6 : 4'h1) :
    ((work_r == 4'h0) ? 4'h0 : work_r - 4'h1);
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      work_r <= 4'h0;
    end else begin
      work_r <= work_nxt;
    end
  end
  assign o_outstanding = (work_r > 4'h1) ? 4'hE : 4'h0;
  assign o_store_pending = (work_r != 4'h0) ? 4'hE : 4'h0;
  assign o_prefetch_busy = i_fetch_en & ~i_kill & 4'hE;
endmodule
